// file: fsi_pkg.sv
// constants and state layout for the framer status and interrupt logic
`default_nettype none

package fsi_pkg;

  // framers sharing one port and one interrupt pin
  localparam int NFR = 4;

  // per-framer register addresses
  localparam logic [7:0] ADR_SR1  = 8'h06;
  localparam logic [7:0] ADR_SR2  = 8'h07;
  localparam logic [7:0] ADR_RIR  = 8'h08;
  localparam logic [7:0] ADR_MASK_REG_ONE = 8'h16;
  localparam logic [7:0] ADR_MASK_REG_TWO = 8'h17;
  localparam logic [7:0] ADR_HDLC_MASK_REG = 8'h18;
  localparam logic [7:0] ADR_SSR  = 8'h1e;
  // summary register answers from here to the top of the map
  localparam logic [7:0] ADR_ISR_LO = 8'hc0;

  // index of a latched register within a framer
  localparam logic [1:0] LR_SR1  = 2'h0;
  localparam logic [1:0] LR_SR2  = 2'h1;
  localparam logic [1:0] LR_RIR  = 2'h2;
  localparam logic [1:0] LR_NONE = 2'h3;
  localparam int         NLR     = 3;

  // state-change alarms sit in the low bits of status_reg_one
  localparam int CHG_W = 4;

  typedef struct packed {
    logic [NFR-1:0][NLR-1:0][7:0] lat;    // sticky status
    logic [NFR-1:0][NLR-1:0][7:0] shown;  // value the host reads
    logic [NFR-1:0][NLR-1:0][7:0] mask;   // last mask byte written
    logic [NFR-1:0][CHG_W-1:0]    chg;    // pending alarm changes
    logic [NFR-1:0][CHG_W-1:0]    prev;   // alarm levels last cycle
    logic [NFR-1:0][7:0]          mask_reg_one;
    logic [NFR-1:0][7:0]          mask_reg_two;
    logic [NFR-1:0][7:0]          hdlc_mask_reg;
    logic [7:0]                   rdData;
    logic                         irq;
  } fsi_state_s;

  localparam fsi_state_s FSI_RST = '0;

endpackage : fsi_pkg

`default_nettype wire

// file: fsi_status_irq.sv
// status latching, mask registers and interrupt summary for four framers
`timescale 1ns/1ns
`default_nettype none

module fsi_status_irq (
  // clock and reset
  input  wire logic                               clk,
  input  wire logic                               rst_b,
  // parallel control port
  input  wire logic [1:0]                         framerSel,
  input  wire logic [7:0]                         addr,
  input  wire logic                               wrEn,
  input  wire logic                               rdEn,
  input  wire logic [7:0]                         wrData,
  output logic      [7:0]                         rdData,
  // live status from the framers
  input  wire logic [fsi_pkg::NFR-1:0][7:0]       sr1Live,
  input  wire logic [fsi_pkg::NFR-1:0][7:0]       sr2Live,
  input  wire logic [fsi_pkg::NFR-1:0][7:0]       rirLive,
  input  wire logic [fsi_pkg::NFR-1:0][7:0]       syncState,
  input  wire logic [fsi_pkg::NFR-1:0][7:0]       hdlcStatus,
  // interrupt pin
  output logic                                    intN
);

  fsi_pkg::fsi_state_s s_q;
  fsi_pkg::fsi_state_s s_d;

  logic [fsi_pkg::NFR-1:0][fsi_pkg::NLR-1:0][7:0] liveAll;
  logic [fsi_pkg::NFR-1:0][fsi_pkg::NLR-1:0][7:0] clr;
  logic [7:0]                                     interrupt_summary;
  logic [7:0]                                     sr1Req;
  logic [1:0]                                     rdIdx;
  logic [1:0]                                     wrIdx;

  ////////////////////////////////////////////////////////////////////////
  // decode of the latched registers

  function automatic logic [1:0] latIdx(input logic [7:0] a);
    logic [1:0] r;
    r = fsi_pkg::LR_NONE;
    if (a == fsi_pkg::ADR_SR1) begin
      r = fsi_pkg::LR_SR1;
    end else if (a == fsi_pkg::ADR_SR2) begin
      r = fsi_pkg::LR_SR2;
    end else if (a == fsi_pkg::ADR_RIR) begin
      r = fsi_pkg::LR_RIR;
    end
    return r;
  endfunction : latIdx

  // alarm bits hold the input level, event bits are single-cycle pulses
  always_comb begin
    for (int f = 0; f < fsi_pkg::NFR; f++) begin
      liveAll[f][fsi_pkg::LR_SR1] = sr1Live[f];
      liveAll[f][fsi_pkg::LR_SR2] = sr2Live[f];
      liveAll[f][fsi_pkg::LR_RIR] = rirLive[f];
    end
  end

  assign rdIdx = latIdx(addr);
  assign wrIdx = latIdx(addr);

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d    = s_q;
    clr    = '0;
    interrupt_summary    = '0;
    sr1Req = '0;

    // a read clears only positions the host masked in and saw as one
    if (rdEn && rdIdx != fsi_pkg::LR_NONE) begin
      clr[framerSel][rdIdx] = s_q.shown[framerSel][rdIdx] & s_q.mask[framerSel][rdIdx];
    end

    for (int f = 0; f < fsi_pkg::NFR; f++) begin
      for (int r = 0; r < fsi_pkg::NLR; r++) begin
        // set wins over clear; a lasting alarm re-sets at once
        s_d.lat[f][r] = (s_q.lat[f][r] & ~clr[f][r]) | liveAll[f][r];
      end
      // both edges of the four alarms raise a request
      s_d.chg[f] = (s_q.chg[f] & ~clr[f][fsi_pkg::LR_SR1][fsi_pkg::CHG_W-1:0])
                 | (sr1Live[f][fsi_pkg::CHG_W-1:0] ^ s_q.prev[f]);
      s_d.prev[f] = sr1Live[f][fsi_pkg::CHG_W-1:0];
    end

    if (wrEn) begin
      if (wrIdx != fsi_pkg::LR_NONE) begin
        // the host follows with a read, then writes back the seen bits
        s_d.mask[framerSel][wrIdx]  = wrData;
        s_d.shown[framerSel][wrIdx] = (s_q.shown[framerSel][wrIdx] & ~wrData)
                                    | (s_q.lat[framerSel][wrIdx] & wrData);
      end else if (addr == fsi_pkg::ADR_MASK_REG_ONE) begin
        s_d.mask_reg_one[framerSel] = wrData;
      end else if (addr == fsi_pkg::ADR_MASK_REG_TWO) begin
        s_d.mask_reg_two[framerSel] = wrData;
      end else if (addr == fsi_pkg::ADR_HDLC_MASK_REG) begin
        s_d.hdlc_mask_reg[framerSel] = wrData;
      end
    end

    // per-framer requests, hdlc above status
    for (int f = 0; f < fsi_pkg::NFR; f++) begin
      // change pending replaces the latched level for the four alarms
      sr1Req = {s_q.lat[f][fsi_pkg::LR_SR1][7:fsi_pkg::CHG_W], s_q.chg[f]};
      interrupt_summary[2*f]   = |(sr1Req & s_q.mask_reg_one[f])
                 | |(s_q.lat[f][fsi_pkg::LR_SR2] & s_q.mask_reg_two[f]);
      interrupt_summary[2*f+1] = |(hdlcStatus[f] & s_q.hdlc_mask_reg[f]);
    end
    s_d.irq = |interrupt_summary;

    // read data; unmapped addresses answer zero
    if (rdEn) begin
      if (addr >= fsi_pkg::ADR_ISR_LO) begin
        s_d.rdData = interrupt_summary;
      end else if (rdIdx != fsi_pkg::LR_NONE) begin
        s_d.rdData = s_q.shown[framerSel][rdIdx];
      end else if (addr == fsi_pkg::ADR_SSR) begin
        s_d.rdData = syncState[framerSel];
      end else if (addr == fsi_pkg::ADR_MASK_REG_ONE) begin
        s_d.rdData = s_q.mask_reg_one[framerSel];
      end else if (addr == fsi_pkg::ADR_MASK_REG_TWO) begin
        s_d.rdData = s_q.mask_reg_two[framerSel];
      end else if (addr == fsi_pkg::ADR_HDLC_MASK_REG) begin
        s_d.rdData = s_q.hdlc_mask_reg[framerSel];
      end else begin
        s_d.rdData = '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= fsi_pkg::FSI_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdData = s_q.rdData;
  // pin released high while nothing is pending
  assign intN   = ~s_q.irq;

endmodule : fsi_status_irq

`default_nettype wire

// file: fsi_status_irq_sva.sv
// port assertions for the framer status and interrupt logic
`timescale 1ns/1ns
`default_nettype none
module fsi_status_irq_sva (
  // clock and reset
  input wire logic            clk,
  input wire logic            rst_b,
  // parallel control port and pin
  input wire logic            wrEn,
  input wire logic            rdEn,
  input wire logic            intN,
  input wire logic [1:0]      framerSel,
  input wire logic [7:0]      addr,
  input wire logic [7:0]      wrData,
  input wire logic [7:0]      rdData,
  // framer status
  input wire logic [3:0][7:0] sr1Live,
  input wire logic [3:0][7:0] sr2Live,
  input wire logic [3:0][7:0] rirLive,
  input wire logic [3:0][7:0] syncState,
  input wire logic [3:0][7:0] hdlcStatus
);
  logic [7:0] m1;
  logic       hdlcAny;
  // framer 0 mask_reg_one copy, so interrupt checks only fire when unmasked
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      m1 <= 8'h00;
    end else if (wrEn && addr == 8'h16 && framerSel == 2'h0) begin
      m1 <= wrData;
    end
  end
  assign hdlcAny = |hdlcStatus;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_ssr_live: assert property (rdEn && addr == 8'h1e && framerSel == 2'h2 |=> rdData == $past(syncState[2]))
    else $error("sync state read wrong");
  a_below_range: assert property (rdEn && addr == 8'hbf |=> rdData == 8'h00)
    else $error("address below summary range answered");
  a_summary_pin: assert property (rdEn && addr >= 8'hc0 |=> (rdData != 8'h00) == !intN)
    else $error("summary and pin disagree");
  a_chg_rise: assert property (m1[2] && $rose(sr1Live[0][2]) |-> ##2 !intN)
    else $error("no interrupt on alarm rise");
  a_chg_fall: assert property (m1[2] && $fell(sr1Live[0][2]) |-> ##2 !intN)
    else $error("no interrupt on alarm fall");
  a_evt_int: assert property (m1[4] && sr1Live[0][4] |-> ##2 !intN)
    else $error("no interrupt on event");
  a_int_release: assert property ($rose(intN) |-> $past(rdEn, 2) || $past(wrEn, 2) || $past(hdlcAny, 2) || $past(hdlcAny, 3))
    else $error("interrupt released without cause");
  a_rd_hold: assert property (!rdEn |=> $stable(rdData))
    else $error("read data moved without a read");
endmodule : fsi_status_irq_sva
bind fsi_status_irq fsi_status_irq_sva u_sva (.clk(clk), .rst_b(rst_b), .wrEn(wrEn), .rdEn(rdEn), .intN(intN),
  .framerSel(framerSel), .addr(addr), .wrData(wrData), .rdData(rdData), .sr1Live(sr1Live), .sr2Live(sr2Live),
  .rirLive(rirLive), .syncState(syncState), .hdlcStatus(hdlcStatus));
`default_nettype wire

// file: fsi_host_model.sv
// host processor model for the parallel control port
`timescale 1ns/1ns
`default_nettype none
module fsi_host_model (
  // port side
  input  wire logic       clk,
  input  wire logic [7:0] rdData,
  output logic      [1:0] framerSel,
  output logic      [7:0] addr,
  output logic      [7:0] wrData,
  output logic            wrEn,
  output logic            rdEn
);
  initial begin
    {framerSel, addr, wrData, wrEn, rdEn} = '0;
  end
  // released address and data invert and both strobes drop, so a stale address is never acted on
  task automatic acc(input logic [1:0] f, input logic [7:0] a, d, input logic w);
    @(posedge clk) #1 {framerSel, addr, wrData, wrEn, rdEn} = {f, a, d, w, !w};
    @(posedge clk) #1 {addr, wrData, wrEn, rdEn} = {~a, ~d, 2'b00};
  endtask : acc
  task automatic rd(input logic [1:0] f, input logic [7:0] a, output logic [7:0] d);
    acc(f, a, 8'h00, 1'b0);
    d = rdData;
  endtask : rd
  task automatic poll(input logic [1:0] f, input logic [7:0] a, m, output logic [7:0] d);
    acc(f, a, m, 1'b1);
    rd(f, a, d);
    acc(f, a, d & m, 1'b1);
  endtask : poll
endmodule : fsi_host_model
`default_nettype wire

// file: fsi_status_irq_tb_top.sv
// self-checking bench for the framer status and interrupt logic
`timescale 1ns/1ns
`default_nettype none
module fsi_status_irq_tb_top;
  logic            clk = 1'b0, rst_b = 1'b0, intN, wrEn, rdEn;
  logic [1:0]      framerSel;
  logic [7:0]      addr, wrData, rdData, v;
  logic [3:0][7:0] sr1Live = '0, sr2Live = '0, rirLive = '0, syncState = '0, hdlcStatus = '0;
  int              err_count = 0, n_tests = 0;
  always #50 clk = ~clk;
  fsi_status_irq u_fsi_status_irq (.clk(clk), .rst_b(rst_b), .framerSel(framerSel), .addr(addr), .wrEn(wrEn),
    .rdEn(rdEn), .wrData(wrData), .rdData(rdData), .sr1Live(sr1Live), .sr2Live(sr2Live), .rirLive(rirLive),
    .syncState(syncState), .hdlcStatus(hdlcStatus), .intN(intN));
  fsi_host_model u_fsi_host_model (.clk(clk), .rdData(rdData), .framerSel(framerSel), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn));
  task automatic complete_run;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // pin is a registered output, so allow a few cycles before judging it
  task automatic waitInt(input logic lvl);
    for (int i = 0; i < 8 && intN !== lvl; i++) @(posedge clk);
    #1 chk({7'h00, intN}, {7'h00, lvl});
    if (intN !== lvl) complete_run();
  endtask : waitInt
  task automatic rc(input logic [1:0] f, input logic [7:0] a, e);
    u_fsi_host_model.rd(f, a, v);
    chk(v, e);
  endtask : rc
  task automatic pc(input logic [1:0] f, input logic [7:0] a, m, e);
    u_fsi_host_model.poll(f, a, m, v);
    chk(v, e);
  endtask : pc
  initial begin
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    waitInt(1'b1);
    syncState[2] = 8'ha5;
    rc(2'h2, 8'h1e, 8'ha5);
    rc(2'h1, 8'hbf, 8'h00);
    u_fsi_host_model.acc(2'h0, 8'h16, 8'h14, 1'b1);
    rc(2'h0, 8'h16, 8'h14);
    sr1Live[0][4] = 1'b1;
    @(posedge clk) #1 sr1Live[0][4] = 1'b0;
    waitInt(1'b0);
    rc(2'h3, 8'hff, 8'h01);
    pc(2'h0, 8'h06, 8'h10, 8'h10);
    waitInt(1'b1);
    pc(2'h0, 8'h06, 8'h10, 8'h00);
    sr1Live[0][2] = 1'b1;
    waitInt(1'b0);
    pc(2'h0, 8'h06, 8'h04, 8'h04);
    waitInt(1'b1);
    pc(2'h0, 8'h06, 8'h04, 8'h04);
    sr1Live[0][2] = 1'b0;
    waitInt(1'b0);
    pc(2'h0, 8'h06, 8'h04, 8'h04);
    waitInt(1'b1);
    sr2Live[1][3] = 1'b1;
    @(posedge clk) #1 sr2Live[1][3] = 1'b0;
    u_fsi_host_model.acc(2'h1, 8'h07, 8'h00, 1'b1);
    rc(2'h1, 8'h07, 8'h00);
    pc(2'h1, 8'h07, 8'h08, 8'h08);
    waitInt(1'b1);
    u_fsi_host_model.acc(2'h2, 8'h18, 8'h01, 1'b1);
    hdlcStatus[2] = 8'h01;
    waitInt(1'b0);
    rc(2'h0, 8'hc0, 8'h20);
    hdlcStatus[2] = 8'h00;
    waitInt(1'b1);
    rirLive[3][7] = 1'b1;
    @(posedge clk) #1 rirLive[3][7] = 1'b0;
    pc(2'h3, 8'h08, 8'h80, 8'h80);
    complete_run();
  end
endmodule : fsi_status_irq_tb_top
`default_nettype wire
